// [pkg/usfc_pkg.sv]
// Shared constants and types of the serial clock-and-frame core.
// Assumes a 32-bit AHB-Lite register bus with word-aligned registers.
package usfc_pkg;
   // Register byte offsets, compared against haddr[7:0].
   localparam logic [7:0] ADDR_DATA = 8'h00;
   localparam logic [7:0] ADDR_CSA = 8'h04;
   localparam logic [7:0] ADDR_CSB = 8'h08;
   localparam logic [7:0] ADDR_CSC = 8'h0C;
   localparam logic [7:0] ADDR_BDL = 8'h10;
   localparam logic [7:0] ADDR_BDH = 8'h14;
   localparam logic [7:0] ADDR_XDIR = 8'h18;
   // ctrl_status_a bit positions.
   localparam int CSA_RXC = 7;
   localparam int CSA_TXC = 6;
   localparam int CSA_UDRE = 5;
   localparam int CSA_FE = 4;
   localparam int CSA_DOR = 3;
   localparam int CSA_PE = 2;
   localparam int CSA_U2X = 1;
   // ctrl_status_b bit positions.
   localparam int CSB_RXCIE = 7;
   localparam int CSB_TXCIE = 6;
   localparam int CSB_UDRIE = 5;
   localparam int CSB_RXEN = 4;
   localparam int CSB_TXEN = 3;
   localparam int CSB_CSZ2 = 2;
   localparam int CSB_RXB8 = 1;
   localparam int CSB_TX_NINTH_BIT = 0;
   // ctrl_status_c bit positions.
   localparam int CSC_SYNC = 6;
   localparam int CSC_PM_LO = 4;
   localparam int CSC_STOP = 3;
   localparam int CSC_CSZ_LO = 1;
   localparam int CSC_POL = 0;
   // Values after reset.
   localparam logic [2:0] CHAR_SIZE_RESET = 3'h3;
   localparam logic [11:0] BAUD_RESET = 12'h000;
   localparam logic RX_IDLE_LEVEL = 1'b1;
   localparam logic XCK_IDLE_LEVEL = 1'b0;
   // Baud ticks per bit minus one, the mid-bit sample phase, and frame format codes.
   localparam logic [3:0] SPB_NORMAL_MAX = 4'hF;
   localparam logic [3:0] SPB_DOUBLE_MAX = 4'h7;
   localparam logic [3:0] MID_NORMAL = 4'h8;
   localparam logic [3:0] MID_DOUBLE = 4'h4;
   localparam logic [3:0] NBITS_NINE = 4'h9;
   localparam logic [2:0] CHAR_SIZE_NINE = 3'h7;
   localparam logic [1:0] PM_EVEN = 2'h2;
   localparam logic [1:0] PM_ODD = 2'h3;

   typedef enum logic [1:0] {M_ASYNC_NORMAL, M_ASYNC_DOUBLE, M_SYNC_MASTER, M_SYNC_SLAVE} usfc_mode_t;
   typedef enum logic [2:0] {ST_IDLE, ST_START, ST_DATA, ST_PARITY, ST_STOP1, ST_STOP2} usfc_frame_st_t;

   typedef struct packed {
      logic [3:0] nbits;
      logic parity_on;
      logic parity_odd;
      logic stop_two;
   } usfc_frame_cfg_t;

   typedef struct packed {
      logic [8:0] data;
      logic framing_err;
      logic parity_err;
   } usfc_rx_entry_t;
endpackage

// [core/usfc_baud_gen.sv]
// Twelve-bit down-counting baud generator.
// Assumes the divisor is stable apart from writes that pulse reload.
`timescale 1ns/100ps
module usfc_baud_gen (
   input wire logic hclk,
   input wire logic hresetn,
   input wire logic [11:0] divisor,
   input wire logic reload,
   output logic tick
);
   logic [11:0] cnt_ff;

   assign tick = (cnt_ff == 12'h000);

   always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         cnt_ff <= 12'h000;
      end else if (reload || tick) begin
         cnt_ff <= divisor;
      end else begin
         cnt_ff <= cnt_ff - 12'h001;
      end
   end
endmodule

// [core/usfc_pin_sync.sv]
// Three-flop pin synchroniser with agreement filter and edge detector.
// Assumes the pin changes no faster than a quarter of hclk.
`timescale 1ns/100ps
module usfc_pin_sync #(
   parameter logic IDLE_LEVEL = 1'b1
) (
   input wire logic hclk,
   input wire logic hresetn,
   input wire logic pin,
   output logic level,
   output logic rise,
   output logic fall
);
   logic s1_ff;
   logic s2_ff;
   logic s3_ff;
   logic level_ff;
   logic change;

   // A change only counts once the second and third stages agree.
   assign change = (s2_ff == s3_ff) && (s3_ff != level_ff);
   assign rise = change && s3_ff;
   assign fall = change && !s3_ff;
   assign level = level_ff;

   always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         s1_ff <= IDLE_LEVEL;
         s2_ff <= IDLE_LEVEL;
         s3_ff <= IDLE_LEVEL;
         level_ff <= IDLE_LEVEL;
      end else begin
         s1_ff <= pin;
         s2_ff <= s1_ff;
         s3_ff <= s2_ff;
         if (change) begin
            level_ff <= s3_ff;
         end
      end
   end
endmodule

// [core/usfc_core.sv]
// Serial transceiver core: clock generation, frame format, parity, AHB-Lite registers.
// Assumes one AHB-Lite master, single word transfers, and a remote serial transceiver on the pins.
//
// Our own choices: the register addresses and the AHB-Lite register port.
`timescale 1ns/100ps
module usfc_core (
   input wire logic hclk,
   input wire logic hresetn,
   input wire logic hsel,
   input wire logic [31:0] haddr,
   input wire logic [1:0] htrans,
   input wire logic hwrite,
   input wire logic [2:0] hsize,
   input wire logic [31:0] hwdata,
   input wire logic hready,
   output logic [31:0] hrdata,
   output logic hreadyout,
   output logic hresp,
   output logic serial_tx_pin,
   input wire logic serial_rx_pin,
   input wire logic xfer_clk_pin_in,
   output logic xfer_clk_pin_out,
   output logic xfer_clk_pin_oe_n,
   output logic irq_rx_complete,
   output logic irq_tx_complete,
   output logic irq_tx_empty
);
   // Configuration registers.
   logic [11:0] baud_divisor_ff;
   logic double_speed_sel_ff;
   logic rx_en_ff;
   logic tx_en_ff;
   logic tx_ninth_bit_ff;
   logic ie_rxc_ff;
   logic ie_txc_ff;
   logic ie_udre_ff;
   logic sync_mode_sel_ff;
   logic [1:0] parity_mode_sel_ff;
   logic stop_bits_sel_ff;
   logic [2:0] char_size_sel_ff;
   logic xfer_clk_polarity_ff;
   logic xfer_clk_dir_ff;

   // Bus state.
   logic ph_valid_ff;
   logic ph_write_ff;
   logic [7:0] ph_addr_ff;
   logic [31:0] hrdata_ff;
   logic take;
   logic rd_take;
   logic wr;

   // Clocking.
   usfc_pkg::usfc_mode_t mode;
   usfc_pkg::usfc_frame_cfg_t cfg;
   logic is_async;
   logic baud_tick;
   logic xck_ff;
   logic xs_rise;
   logic xs_fall;
   logic xck_rise;
   logic xck_fall;
   logic change_edge;
   logic sample_edge;
   logic [3:0] spb_max;
   logic [3:0] mid;
   logic [3:0] tx_div_ff;
   logic tx_bit_tick;
   logic [8:0] mask;

   // Transmitter.
   logic [8:0] txb_data_ff;
   logic txb_full_ff;
   usfc_pkg::usfc_frame_st_t tx_st_ff;
   logic [8:0] tx_sh_ff;
   logic [3:0] tx_idx_ff;
   logic tx_line_ff;
   logic tx_par_ff;
   logic tx_active_ff;
   logic tx_complete_ff;
   logic tx_load;
   logic tx_done_ev;

   // Receiver.
   logic rx_s;
   usfc_pkg::usfc_frame_st_t rx_st_ff;
   logic [3:0] rx_phase_ff;
   logic [3:0] rx_idx_ff;
   logic [8:0] rx_sh_ff;
   logic rx_par_ff;
   logic rx_sample;
   logic rx_push;
   usfc_pkg::usfc_rx_entry_t rx_new;
   usfc_pkg::usfc_rx_entry_t rx_q_ff [2];
   usfc_pkg::usfc_rx_entry_t rx_head;
   logic rx_wr_ptr_ff;
   logic rx_rd_ptr_ff;
   logic [1:0] rx_cnt_ff;
   logic rx_pop;
   logic overrun_ff;

   function automatic logic [3:0] data_bits(input logic [2:0] code);
      logic [3:0] n;
      n = 4'h8;
      if (code == usfc_pkg::CHAR_SIZE_NINE) begin
         n = usfc_pkg::NBITS_NINE;
      end else if (code[2] == 1'b0) begin
         n = 4'h5 + {2'b00, code[1:0]};
      end
      return n;
   endfunction

   // Frame settings feed both directions from one copy.
   assign cfg.nbits = data_bits(char_size_sel_ff);
   assign cfg.parity_on = parity_mode_sel_ff[1];
   assign cfg.parity_odd = (parity_mode_sel_ff == usfc_pkg::PM_ODD);
   assign cfg.stop_two = stop_bits_sel_ff;
   assign mask = 9'h1FF >> (4'h9 - cfg.nbits);

   always_comb begin
      if (!sync_mode_sel_ff) begin
         mode = double_speed_sel_ff ? usfc_pkg::M_ASYNC_DOUBLE : usfc_pkg::M_ASYNC_NORMAL;
      end else begin
         mode = xfer_clk_dir_ff ? usfc_pkg::M_SYNC_MASTER : usfc_pkg::M_SYNC_SLAVE;
      end
   end
   assign is_async = !sync_mode_sel_ff;
   assign spb_max = (mode == usfc_pkg::M_ASYNC_DOUBLE) ? usfc_pkg::SPB_DOUBLE_MAX : usfc_pkg::SPB_NORMAL_MAX;
   assign mid = (mode == usfc_pkg::M_ASYNC_DOUBLE) ? usfc_pkg::MID_DOUBLE : usfc_pkg::MID_NORMAL;

   // AHB-Lite slave: zero wait states, always OKAY.
   assign take = hsel && hready && htrans[1];
   assign rd_take = take && !hwrite;
   assign wr = ph_valid_ff && ph_write_ff;
   assign hreadyout = 1'b1;
   assign hresp = 1'b0;
   assign hrdata = hrdata_ff;

   always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         ph_valid_ff <= 1'b0;
         ph_write_ff <= 1'b0;
         ph_addr_ff <= 8'h00;
      end else begin
         ph_valid_ff <= take;
         ph_write_ff <= hwrite;
         ph_addr_ff <= haddr[7:0];
      end
   end

   // Read data is captured at the address phase, so a read of the data register pops there.
   always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         hrdata_ff <= 32'h0000_0000;
      end else if (rd_take) begin
         hrdata_ff <= 32'h0000_0000;
         unique case (haddr[7:0])
            usfc_pkg::ADDR_DATA: hrdata_ff[7:0] <= rx_head.data[7:0];
            usfc_pkg::ADDR_CSA: hrdata_ff[7:0] <= {rx_cnt_ff != 2'h0, tx_complete_ff, !txb_full_ff,
               rx_head.framing_err, overrun_ff, rx_head.parity_err, double_speed_sel_ff, 1'b0};
            usfc_pkg::ADDR_CSB: hrdata_ff[7:0] <= {ie_rxc_ff, ie_txc_ff, ie_udre_ff, rx_en_ff, tx_en_ff,
               char_size_sel_ff[2], rx_head.data[8], tx_ninth_bit_ff};
            usfc_pkg::ADDR_CSC: hrdata_ff[7:0] <= {1'b0, sync_mode_sel_ff, parity_mode_sel_ff, stop_bits_sel_ff,
               char_size_sel_ff[1:0], xfer_clk_polarity_ff};
            usfc_pkg::ADDR_BDL: hrdata_ff[7:0] <= baud_divisor_ff[7:0];
            usfc_pkg::ADDR_BDH: hrdata_ff[3:0] <= baud_divisor_ff[11:8];
            usfc_pkg::ADDR_XDIR: hrdata_ff[0] <= xfer_clk_dir_ff;
            default: hrdata_ff <= 32'h0000_0000;
         endcase
      end
   end

   always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         baud_divisor_ff <= usfc_pkg::BAUD_RESET;
         double_speed_sel_ff <= 1'b0;
         rx_en_ff <= 1'b0;
         tx_en_ff <= 1'b0;
         tx_ninth_bit_ff <= 1'b0;
         ie_rxc_ff <= 1'b0;
         ie_txc_ff <= 1'b0;
         ie_udre_ff <= 1'b0;
         sync_mode_sel_ff <= 1'b0;
         parity_mode_sel_ff <= 2'h0;
         stop_bits_sel_ff <= 1'b0;
         char_size_sel_ff <= usfc_pkg::CHAR_SIZE_RESET;
         xfer_clk_polarity_ff <= 1'b0;
         xfer_clk_dir_ff <= 1'b0;
      end else if (wr) begin
         unique case (ph_addr_ff)
            usfc_pkg::ADDR_CSA: double_speed_sel_ff <= hwdata[usfc_pkg::CSA_U2X];
            usfc_pkg::ADDR_CSB: begin
               ie_rxc_ff <= hwdata[usfc_pkg::CSB_RXCIE];
               ie_txc_ff <= hwdata[usfc_pkg::CSB_TXCIE];
               ie_udre_ff <= hwdata[usfc_pkg::CSB_UDRIE];
               rx_en_ff <= hwdata[usfc_pkg::CSB_RXEN];
               tx_en_ff <= hwdata[usfc_pkg::CSB_TXEN];
               char_size_sel_ff[2] <= hwdata[usfc_pkg::CSB_CSZ2];
               tx_ninth_bit_ff <= hwdata[usfc_pkg::CSB_TX_NINTH_BIT];
            end
            usfc_pkg::ADDR_CSC: begin
               sync_mode_sel_ff <= hwdata[usfc_pkg::CSC_SYNC];
               parity_mode_sel_ff <= hwdata[usfc_pkg::CSC_PM_LO +: 2];
               stop_bits_sel_ff <= hwdata[usfc_pkg::CSC_STOP];
               char_size_sel_ff[1:0] <= hwdata[usfc_pkg::CSC_CSZ_LO +: 2];
               xfer_clk_polarity_ff <= hwdata[usfc_pkg::CSC_POL];
            end
            usfc_pkg::ADDR_BDL: baud_divisor_ff[7:0] <= hwdata[7:0];
            usfc_pkg::ADDR_BDH: baud_divisor_ff[11:8] <= hwdata[3:0];
            usfc_pkg::ADDR_XDIR: xfer_clk_dir_ff <= hwdata[0];
            default: ;
         endcase
      end
   end

   usfc_baud_gen u_baud (
      .hclk(hclk),
      .hresetn(hresetn),
      .divisor(baud_divisor_ff),
      .reload(wr && (ph_addr_ff == usfc_pkg::ADDR_BDL)),
      .tick(baud_tick)
   );

   usfc_pin_sync #(.IDLE_LEVEL(usfc_pkg::XCK_IDLE_LEVEL)) u_xck_sync (
      .hclk(hclk),
      .hresetn(hresetn),
      .pin(xfer_clk_pin_in),
      .level(),
      .rise(xs_rise),
      .fall(xs_fall)
   );

   usfc_pin_sync #(.IDLE_LEVEL(usfc_pkg::RX_IDLE_LEVEL)) u_rx_sync (
      .hclk(hclk),
      .hresetn(hresetn),
      .pin(serial_rx_pin),
      .level(rx_s),
      .rise(),
      .fall()
   );

   // Master clock toggles on every baud tick, so one bit spans two ticks.
   always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         xck_ff <= usfc_pkg::XCK_IDLE_LEVEL;
      end else if (mode != usfc_pkg::M_SYNC_MASTER) begin
         xck_ff <= usfc_pkg::XCK_IDLE_LEVEL;
      end else if (baud_tick) begin
         xck_ff <= !xck_ff;
      end
   end
   // The flop lags a mode change by one edge, so the pin is gated to stay idle the moment master mode ends.
   assign xfer_clk_pin_out = xck_ff && (mode == usfc_pkg::M_SYNC_MASTER);
   assign xfer_clk_pin_oe_n = (mode != usfc_pkg::M_SYNC_MASTER);

   // Slave edges are ignored outside slave mode.
   assign xck_rise = (mode == usfc_pkg::M_SYNC_MASTER) ? (baud_tick && !xck_ff) :
                     ((mode == usfc_pkg::M_SYNC_SLAVE) && xs_rise);
   assign xck_fall = (mode == usfc_pkg::M_SYNC_MASTER) ? (baud_tick && xck_ff) :
                     ((mode == usfc_pkg::M_SYNC_SLAVE) && xs_fall);
   assign change_edge = xfer_clk_polarity_ff ? xck_fall : xck_rise;
   assign sample_edge = xfer_clk_polarity_ff ? xck_rise : xck_fall;

   always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         tx_div_ff <= 4'h0;
      end else if (!is_async || !tx_en_ff) begin
         tx_div_ff <= 4'h0;
      end else if (baud_tick) begin
         tx_div_ff <= (tx_div_ff >= spb_max) ? 4'h0 : tx_div_ff + 4'h1;
      end
   end
   assign tx_bit_tick = is_async ? (baud_tick && (tx_div_ff >= spb_max)) : change_edge;

   // Transmit buffer: a write while full is dropped so the buffered character is never torn.
   assign tx_load = tx_en_ff && tx_bit_tick && (tx_st_ff == usfc_pkg::ST_IDLE) && txb_full_ff;
   assign tx_done_ev = tx_en_ff && tx_bit_tick && (tx_st_ff == usfc_pkg::ST_IDLE) && !txb_full_ff && tx_active_ff;

   always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         txb_data_ff <= 9'h000;
         txb_full_ff <= 1'b0;
      end else if (tx_load) begin
         txb_full_ff <= 1'b0;
      end else if (wr && (ph_addr_ff == usfc_pkg::ADDR_DATA) && !txb_full_ff) begin
         txb_data_ff <= {tx_ninth_bit_ff, hwdata[7:0]};
         txb_full_ff <= 1'b1;
      end
   end

   always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         tx_st_ff <= usfc_pkg::ST_IDLE;
         tx_sh_ff <= 9'h000;
         tx_idx_ff <= 4'h0;
         tx_line_ff <= 1'b1;
         tx_par_ff <= 1'b0;
         tx_active_ff <= 1'b0;
      end else if (!tx_en_ff) begin
         tx_st_ff <= usfc_pkg::ST_IDLE;
         tx_line_ff <= 1'b1;
         tx_active_ff <= 1'b0;
      end else if (tx_bit_tick) begin
         unique case (tx_st_ff)
            usfc_pkg::ST_IDLE: begin
               tx_line_ff <= 1'b1;
               tx_active_ff <= txb_full_ff;
               if (txb_full_ff) begin
                  tx_sh_ff <= txb_data_ff;
                  tx_par_ff <= (^(txb_data_ff & mask)) ^ cfg.parity_odd;
                  tx_line_ff <= 1'b0;
                  tx_idx_ff <= 4'h0;
                  tx_st_ff <= usfc_pkg::ST_DATA;
               end
            end
            usfc_pkg::ST_DATA: begin
               tx_line_ff <= tx_sh_ff[tx_idx_ff];
               tx_idx_ff <= tx_idx_ff + 4'h1;
               if (tx_idx_ff == cfg.nbits - 4'h1) begin
                  tx_st_ff <= cfg.parity_on ? usfc_pkg::ST_PARITY : usfc_pkg::ST_STOP1;
               end
            end
            usfc_pkg::ST_PARITY: begin
               tx_line_ff <= tx_par_ff;
               tx_st_ff <= usfc_pkg::ST_STOP1;
            end
            usfc_pkg::ST_STOP1: begin
               tx_line_ff <= 1'b1;
               tx_st_ff <= cfg.stop_two ? usfc_pkg::ST_STOP2 : usfc_pkg::ST_IDLE;
            end
            usfc_pkg::ST_STOP2: begin
               tx_line_ff <= 1'b1;
               tx_st_ff <= usfc_pkg::ST_IDLE;
            end
            default: tx_st_ff <= usfc_pkg::ST_IDLE;
         endcase
      end
   end
   assign serial_tx_pin = tx_line_ff;

   // Completion set wins over a software clear in the same cycle.
   always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         tx_complete_ff <= 1'b0;
      end else if (tx_done_ev) begin
         tx_complete_ff <= 1'b1;
      end else if (wr && (ph_addr_ff == usfc_pkg::ADDR_CSA) && hwdata[usfc_pkg::CSA_TXC]) begin
         tx_complete_ff <= 1'b0;
      end
   end

   // Receiver: a single mid-bit sample per bit, so the baud setting must be accurate.
   assign rx_sample = is_async ? (baud_tick && (rx_phase_ff == mid)) : sample_edge;
   assign rx_push = rx_sample && (rx_st_ff == usfc_pkg::ST_STOP1);
   assign rx_new.data = rx_sh_ff & mask;
   assign rx_new.framing_err = !rx_s;
   assign rx_new.parity_err = cfg.parity_on && ((^(rx_sh_ff & mask)) ^ cfg.parity_odd ^ rx_par_ff);

   always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         rx_phase_ff <= 4'h0;
      end else if (!is_async || (rx_st_ff == usfc_pkg::ST_IDLE)) begin
         rx_phase_ff <= 4'h1;
      end else if (baud_tick) begin
         rx_phase_ff <= (rx_phase_ff >= spb_max) ? 4'h0 : rx_phase_ff + 4'h1;
      end
   end

   always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         rx_st_ff <= usfc_pkg::ST_IDLE;
         rx_idx_ff <= 4'h0;
         rx_sh_ff <= 9'h000;
         rx_par_ff <= 1'b0;
      end else if (!rx_en_ff) begin
         rx_st_ff <= usfc_pkg::ST_IDLE;
      end else if (rx_st_ff == usfc_pkg::ST_IDLE) begin
         rx_idx_ff <= 4'h0;
         rx_sh_ff <= 9'h000;
         if (is_async && baud_tick && !rx_s) begin
            rx_st_ff <= usfc_pkg::ST_START;
         end else if (!is_async && sample_edge && !rx_s) begin
            rx_st_ff <= usfc_pkg::ST_DATA;
         end
      end else if (rx_sample) begin
         unique case (rx_st_ff)
            usfc_pkg::ST_START: rx_st_ff <= rx_s ? usfc_pkg::ST_IDLE : usfc_pkg::ST_DATA;
            usfc_pkg::ST_DATA: begin
               rx_sh_ff[rx_idx_ff] <= rx_s;
               rx_idx_ff <= rx_idx_ff + 4'h1;
               if (rx_idx_ff == cfg.nbits - 4'h1) begin
                  rx_st_ff <= cfg.parity_on ? usfc_pkg::ST_PARITY : usfc_pkg::ST_STOP1;
               end
            end
            usfc_pkg::ST_PARITY: begin
               rx_par_ff <= rx_s;
               rx_st_ff <= usfc_pkg::ST_STOP1;
            end
            default: rx_st_ff <= usfc_pkg::ST_IDLE;
         endcase
      end
   end

   // Two-entry receive buffer.
   assign rx_pop = rd_take && (haddr[7:0] == usfc_pkg::ADDR_DATA) && (rx_cnt_ff != 2'h0);
   assign rx_head = (rx_cnt_ff != 2'h0) ? rx_q_ff[rx_rd_ptr_ff] : '0;

   for (genvar i = 0; i < 2; i++) begin : g_rxq
      always_ff @(posedge hclk or negedge hresetn) begin
         if (!hresetn) begin
            rx_q_ff[i] <= '0;
         end else if (rx_push && (rx_cnt_ff != 2'h2) && (rx_wr_ptr_ff == 1'(i))) begin
            rx_q_ff[i] <= rx_new;
         end
      end
   end

   always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         rx_wr_ptr_ff <= 1'b0;
         rx_rd_ptr_ff <= 1'b0;
         rx_cnt_ff <= 2'h0;
      end else begin
         if (rx_push && (rx_cnt_ff != 2'h2)) begin
            rx_wr_ptr_ff <= !rx_wr_ptr_ff;
         end
         if (rx_pop) begin
            rx_rd_ptr_ff <= !rx_rd_ptr_ff;
         end
         rx_cnt_ff <= rx_cnt_ff + {1'b0, rx_push && (rx_cnt_ff != 2'h2)} - {1'b0, rx_pop};
      end
   end

   // Overrun set wins over the clear by a data read in the same cycle.
   always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         overrun_ff <= 1'b0;
      end else if (rx_push && (rx_cnt_ff == 2'h2)) begin
         overrun_ff <= 1'b1;
      end else if (rx_pop) begin
         overrun_ff <= 1'b0;
      end
   end

   assign irq_rx_complete = ie_rxc_ff && (rx_cnt_ff != 2'h0);
   assign irq_tx_complete = ie_txc_ff && tx_complete_ff;
   assign irq_tx_empty = ie_udre_ff && !txb_full_ff;
endmodule

// [tb/usfc_props.sv]
// Port checker of the serial clock-and-frame core.
// Assumes it is bound to usfc_core and sees its ports alone.
`timescale 1ns/100ps
module usfc_props (
   input wire logic hclk,
   input wire logic hresetn,
   input wire logic hsel,
   input wire logic [1:0] htrans,
   input wire logic hwrite,
   input wire logic hready,
   input wire logic hreadyout,
   input wire logic hresp,
   input wire logic serial_tx_pin,
   input wire logic xfer_clk_pin_out,
   input wire logic xfer_clk_pin_oe_n,
   input wire logic irq_tx_complete,
   input wire logic irq_tx_empty
);
   default clocking @(posedge hclk); endclocking
   default disable iff (!hresetn);
   logic wtake;
   assign wtake = hsel && hready && htrans[1] && hwrite;
   sequence s_answer;
      hreadyout ##1 hreadyout;
   endsequence
   a_bus_ready: assert property (wtake |-> s_answer) else $error("bus answer delayed");
   a_bus_okay: assert property (!hresp) else $error("bus response not okay");
   a_clk_idle: assert property (xfer_clk_pin_oe_n |-> !xfer_clk_pin_out) else $error("clock out driven");
   a_tx_width: assert property ($changed(serial_tx_pin) |=> $stable(serial_tx_pin)) else $error("bit too short");
   a_reset_idle: assert property ($rose(hresetn) |-> serial_tx_pin && xfer_clk_pin_oe_n) else $error("not idle");
   a_mode_cause: assert property ($changed(xfer_clk_pin_oe_n) |-> $past(wtake, 2)) else $error("pin dir moved");
   a_irq_fall: assert property ($fell(irq_tx_empty) |-> $past(wtake, 2)) else $error("empty fell alone");
   a_txc_line: assert property ($rose(irq_tx_complete) |-> serial_tx_pin) else $error("done mid frame");
endmodule
bind usfc_core usfc_props usfc_props_i (.hclk, .hresetn, .hsel, .htrans, .hwrite, .hready, .hreadyout, .hresp,
   .serial_tx_pin, .xfer_clk_pin_out, .xfer_clk_pin_oe_n, .irq_tx_complete, .irq_tx_empty);

// [tb/usfc_remote.sv]
// Remote serial transceiver on the transmit and receive lines.
// Assumes its tasks are called just after a rising hclk edge.
`timescale 1ns/100ps
module usfc_remote (
   input wire logic hclk,
   input wire logic serial_tx_pin,
   output logic serial_rx_pin
);
   logic [12:0] got;
   logic lost = 1'b0;
   initial serial_rx_pin = 1'b1;
   // A missing start bit sets lost and leaves an all-ones frame; the bench flags lost.
   task automatic recv(input int bpb, input int n);
      int i;
      got = '1;
      for (i = 0; i < 9000 && serial_tx_pin; i++) @(posedge hclk);
      lost = serial_tx_pin;
      repeat (bpb / 2) @(posedge hclk);
      for (i = 0; i < n; i++) begin
         repeat (bpb) @(posedge hclk);
         got[i] = serial_tx_pin;
      end
   endtask
   task automatic send(input int bpb, input int n, input logic [12:0] v);
      int i;
      for (i = -1; i < n; i++) begin
         serial_rx_pin <= (i < 0) ? 1'b0 : v[i];
         repeat (bpb) @(posedge hclk);
      end
      serial_rx_pin <= 1'b1;
      // One idle bit lets the last stop sample land before the caller reads the result.
      repeat (bpb) @(posedge hclk);
   endtask
endmodule

// [tb/usfc_core_test.sv]
// Self-checking bench of usfc_core: registers, clock modes and frame formats.
// Assumes the checker and the remote model are compiled first.
`timescale 1ns/100ps
`define CHK(a, b) begin n_compared++; if ((a) !== (b)) begin mismatches++; $display("[FAIL] %0t %h %h", $time, a, b); end end
`define SEE(a, b) @(negedge hclk); `CHK(a, b) @(posedge hclk);
module usfc_core_test;
   logic hclk = 1'b0, hresetn = 1'b0, hsel = 1'b0, hwrite = 1'b0, xck = 1'b0, irq_rx_complete;
   logic [1:0] htrans = 2'h0;
   logic [31:0] haddr = 32'h0000_0000, hwdata = 32'h0000_0000, rd, hrdata;
   logic hreadyout, serial_tx_pin, serial_rx_pin, xfer_clk_pin_oe_n, irq_tx_empty;
   int mismatches = 0, n_compared = 0, seed = 32'h0000_b08e;
   usfc_core usfc_core_i (.hclk, .hresetn, .hsel, .haddr, .htrans, .hwrite, .hsize(3'h2), .hwdata,
      .hready(hreadyout), .hrdata, .hreadyout, .hresp(), .serial_tx_pin, .serial_rx_pin, .xfer_clk_pin_in(xck),
      .xfer_clk_pin_out(), .xfer_clk_pin_oe_n, .irq_rx_complete, .irq_tx_complete(), .irq_tx_empty);
   usfc_remote usfc_remote_i (.hclk, .serial_tx_pin, .serial_rx_pin);
   initial forever #5 hclk = ~hclk;
   task automatic test_done;
      if (mismatches == 0 && n_compared > 0) $display("All checks passed");
      else $display("Checks failed");
      $finish;
   endtask
   task automatic hold;
      int i;
      i = 0;
      do @(posedge hclk); while (hreadyout !== 1'b1 && ++i < 50);
      if (i >= 50) begin mismatches++; test_done; end
   endtask
   task automatic bus(input logic w, input logic [7:0] a, input logic [31:0] d);
      hsel <= 1'b1;
      htrans <= 2'h2;
      hwrite <= w;
      haddr <= {24'h00_0000, a};
      hold;
      hsel <= 1'b0;
      htrans <= 2'h0;
      hwdata <= d;
      hold;
      rd = hrdata;
   endtask
   function automatic logic [12:0] frame(logic [8:0] d, int nd, int pm, logic pe, logic fe);
      logic [12:0] v;
      logic p;
      v = '1;
      p = pm[0];
      for (int k = 0; k < nd; k++) begin v[k] = d[k]; p ^= d[k]; end
      if (pm[1]) begin v[nd] = p ^ pe; nd++; end
      v[nd] = !fe;
      return v;
   endfunction
   initial begin
      int dv, ds, cs, nd, pm, sb, pe, fe, bpb;
      logic [8:0] d;
      repeat (20) @(posedge hclk);
      hresetn <= 1'b1;
      @(posedge hclk);
      bus(0, usfc_pkg::ADDR_CSA, 0);
      `CHK(rd, 32'h0000_0020)
      bus(0, usfc_pkg::ADDR_CSC, 0);
      `CHK(rd, 32'h0000_0006)
      bus(1, usfc_pkg::ADDR_BDH, 32'h0000_00FF);
      bus(0, usfc_pkg::ADDR_BDH, 0);
      `CHK(rd, 32'h0000_000F)
      bus(1, usfc_pkg::ADDR_BDH, 0);
      bus(0, 8'h1C, 0);
      `CHK(rd, 32'h0000_0000)
      bus(1, usfc_pkg::ADDR_XDIR, 1);
      `SEE(xfer_clk_pin_oe_n, 1'b1)
      bus(1, usfc_pkg::ADDR_CSC, 32'h0000_0040);
      `SEE(xfer_clk_pin_oe_n, 1'b0)
      bus(1, usfc_pkg::ADDR_XDIR, 0);
      bus(1, usfc_pkg::ADDR_CSB, 32'h0000_0008);
      bus(1, usfc_pkg::ADDR_DATA, 32'h0000_0016);
      fork
         repeat (40) begin repeat (4) @(posedge hclk); xck <= ~xck; end
         usfc_remote_i.recv(8, 6);
      join
      if (usfc_remote_i.lost) begin mismatches++; test_done; end
      `CHK(usfc_remote_i.got, frame(9'h016, 5, 0, 0, 0))
      for (int k = 0; k < 12; k++) begin
         dv = $unsigned($random(seed)) % 3;
         ds = $random(seed) & 1;
         cs = $unsigned($random(seed)) % 5;
         pm = $unsigned($random(seed)) % 4;
         sb = $random(seed) & 1;
         d = 9'($random(seed));
         cs = (cs == 4) ? 7 : cs;
         nd = (cs == 7) ? 9 : cs + 5;
         bpb = (dv + 1) * (ds ? 8 : 16);
         bus(1, usfc_pkg::ADDR_BDL, 32'(dv));
         bus(1, usfc_pkg::ADDR_CSA, 32'(ds << 1));
         bus(1, usfc_pkg::ADDR_CSB, 32'(248 | (cs & 4) | d[8]));
         bus(1, usfc_pkg::ADDR_CSC, 32'((pm << 4) | (sb << 3) | ((cs & 3) << 1)));
         `SEE(irq_tx_empty, 1'b1)
         bus(1, usfc_pkg::ADDR_DATA, 32'(d[7:0]));
         usfc_remote_i.recv(bpb, nd + pm / 2 + 1 + sb);
         if (usfc_remote_i.lost) begin mismatches++; test_done; end
         `CHK(usfc_remote_i.got, frame(d, nd, pm, 0, 0))
         pe = $random(seed) & 1;
         fe = $random(seed) & sb;
         d = 9'($random(seed));
         usfc_remote_i.send(bpb, nd + pm / 2 + 1 + sb, frame(d, nd, pm, pe, fe));
         `SEE(irq_rx_complete, 1'b1)
         bus(0, usfc_pkg::ADDR_CSA, 0);
         `CHK(rd[4:2], 3'(fe * 4 + (pe & (pm >> 1))))
         bus(0, usfc_pkg::ADDR_DATA, 0);
         `CHK(rd, 32'(d & (2 ** nd - 1) & 255))
      end
      test_done;
   end
endmodule
